/* File: src/preset_ramp_defs.svh */
// register offsets, field positions, reset values and timing constants of the preset sequencer
`ifndef PRESET_RAMP_DEFS_SVH
`define PRESET_RAMP_DEFS_SVH

// register offsets
`define OFS_PRESET_A      8'h00
`define OFS_PRESET_B      8'h01
`define OFS_RAMP_CTRL     8'h06
`define OFS_RAMP_STATUS   8'h07

// field positions
`define MODE_BIT          7
`define CODE_MSB          6
`define RATE_MSB          2
`define RAMP_DOWN_BIT     3
`define STATUS_BUSY_BIT   7

// register interface address
`define DEV_ADDR          7'h60

// reset values: voltage codes are (millivolts - 500) / 10
`define RST_A_VAR0        7'h46
`define RST_B_VAR0        7'h42
`define RST_A_VAR1        7'h2E
`define RST_B_VAR1        7'h5A
`define RST_MODE          1'h0
`define RST_RATE          3'h0
`define RST_RAMP_DOWN     1'h0

// timing: one 20 mV increment at rate code zero, and the clock period
`define STEP20_TIME_PS    625000
`define CLK_PERIOD_PS     4000
`define ACC_FRAC          4
`define STEP20_QCYC       ((`STEP20_TIME_PS * `ACC_FRAC) / `CLK_PERIOD_PS)
`define SS_TIME_US        100
`define SS_CYCLES_DFLT    ((`SS_TIME_US * 1000000) / `CLK_PERIOD_PS)

`endif

/* File: src/preset_ramp_pkg.sv */
// types shared by the preset sequencer and its environment
package preset_ramp_pkg;

    // one register access delivered by the serial interface engine at command end
    typedef struct packed {
        logic       valid;        // one-cycle strobe: command completed
        logic       write;        // 1 = write, 0 = read
        logic       ten_bit;      // access came with a 10-bit address
        logic       general_call; // access came as a general call
        logic [6:0] dev_addr;     // 7-bit slave address of the access
        logic [7:0] reg_addr;     // register offset
        logic [7:0] wdata;        // write data
    } reg_req_type;

    // setpoint and mode handed to the analog regulation loop
    typedef struct packed {
        logic       run;          // power stage switching
        logic       soft_start;   // monotonic start-up toward the minimum level
        logic       fpwm;         // forced pwm, else power save
        logic       sink_enable;  // may return energy from the output
        logic [6:0] setpoint;     // current setpoint code
    } reg_loop_type;

    // sequencer states
    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_SOFT = 2'b01,
        ST_RAMP = 2'b10,
        ST_REG  = 2'b11
    } seq_state_type;

endpackage : preset_ramp_pkg

/* File: src/voltage_preset_ramp_sequencer.sv */
// voltage preset store, preset selection and setpoint ramp sequencer
//
// Notes on behaviour
// - select pin low uses preset a, high b
// - presets default power save, variant voltages
// - 7-bit code, 500 mV plus 10 mV steps
// - bit 7 chooses power save or forced pwm
// - active preset writes apply at command end
// - inactive preset writes wait for select change
// - active preset mode bit applies immediately
// - one ramp rate for both presets
// - slope is 32 mV/us over two^code
// - 20 mV increments, final 10 mV if needed
// - increment timing from dedicated internal timebase
// - forced pwm enforces slope both directions
// - power save rising follows programmed slope
// - ramp-down bit enforces falling slope in power save
// - otherwise power save falling returns no energy
// - soft start to minimum, then ramp to target
// - soft start tolerates pre-biased output
// - enable starts/stops, registers always accessible
// - supply undervoltage reset restores all defaults
// - answer only 7-bit address, ignore others
`include "preset_ramp_defs.svh"

module voltage_preset_ramp_sequencer
#(
    parameter bit          VARIANT   = 1'b0,            // selects the default voltage pair
    parameter int unsigned SS_CYCLES = `SS_CYCLES_DFLT  // soft start duration in clocks
)
(
    input  wire logic                        clk,
    input  wire logic                        srst,               // supply undervoltage reset
    input  wire logic                        enable_pin,         // asynchronous enable pin
    input  wire logic                        preset_select_pin,  // asynchronous preset select
    input  wire preset_ramp_pkg::reg_req_type req,               // access from the serial engine
    output wire logic                        addr_ack,           // access addressed to us
    output logic      [7:0]                  rd_data,            // read data, registered
    output preset_ramp_pkg::reg_loop_type    loop                // toward the regulation loop
);
    import preset_ramp_pkg::*;

    // the accumulator must hold the slowest spacing plus one clock of quarter cycles
    // 625 quarter clocks shifted by up to 7 fits 17 bits; the spare bit takes the carry
    localparam int unsigned ACC_W = 18;

    // refuse a soft start shorter than one clock
    if (SS_CYCLES < 1)
    begin : g_bad_ss
        $error("SS_CYCLES must be at least one");
    end

    // spacing in quarter clocks for one increment; half for the closing 10 mV
    // the half is truncated, so the closing step may come half a quarter clock early
    function automatic logic [ACC_W-1:0] step_need(input logic [2:0] rate, input logic half);
        logic [ACC_W-1:0] full;
        full = ACC_W'(`STEP20_QCYC) << rate;
        step_need = half ? (full >> 1) : full;
    endfunction : step_need

    // distance between two codes, magnitude only
    function automatic logic [6:0] code_dist(input logic [6:0] a, input logic [6:0] b);
        code_dist = (a > b) ? 7'(a - b) : 7'(b - a);
    endfunction : code_dist

    // pin synchronisers: first stage is read only by the second
    logic en_meta_r;        // enable, first stage
    logic en_sync_r;        // enable, second stage
    logic sel_meta_r;       // preset select, first stage
    logic sel_sync_r;       // preset select, second stage

    // register file
    logic [6:0] code_a_r;   // preset a voltage code
    logic [6:0] code_b_r;   // preset b voltage code
    logic       mode_a_r;   // preset a mode bit
    logic       mode_b_r;   // preset b mode bit
    logic [2:0] rate_r;     // global ramp rate code
    logic       ramp_down_ps_r; // ramp down also in power save

    // sequencer state
    seq_state_type    state_r;     // current phase
    seq_state_type    state_nxt;   // next phase
    logic [6:0]       set_r;       // present setpoint code
    logic [6:0]       set_nxt;     // next setpoint code
    logic [ACC_W-1:0] acc_r;       // ramp timebase accumulator
    logic [ACC_W-1:0] acc_nxt;     // next accumulator value
    logic [31:0]      ss_cnt_r;    // soft start elapsed clocks
    logic [31:0]      ss_cnt_nxt;  // next soft start count

    // outputs held in flops
    reg_loop_type loop_r;     // registered loop controls
    reg_loop_type loop_nxt;   // their next value
    logic [7:0]   rd_nxt;     // next read data

    // access decode
    wire        addr_hit;     // access is for this slave
    wire        wr_hit;       // accepted write
    wire        rd_hit;       // accepted read
    wire        wr_a;         // write to preset a
    wire        wr_b;         // write to preset b
    wire        wr_ctrl;      // write to ramp control
    wire [7:0]  rd_mux;       // selected read value

    // active preset view
    wire [6:0]  target;       // code of the active preset
    wire        fpwm;         // forced pwm of the active preset
    wire        rising;       // setpoint below target
    wire        falling;      // setpoint above target
    wire        enforce_down; // falling must follow the slope
    wire        moving;       // a timed increment is pending
    wire        small_step;   // only 10 mV left
    wire [ACC_W-1:0] need;    // spacing for the pending increment
    wire [ACC_W-1:0] acc_inc; // accumulator after this clock
    wire        step_due;     // timebase says take the increment
    wire        ss_done;      // soft start time elapsed

    // answer only a plain 7-bit address match; 10-bit and general call never match
    assign addr_hit = req.valid && !req.ten_bit && !req.general_call
                      && (req.dev_addr == `DEV_ADDR);
    assign addr_ack = addr_hit;
    // register access does not depend on enable
    assign wr_hit  = addr_hit && req.write;
    assign rd_hit  = addr_hit && !req.write;
    assign wr_a    = wr_hit && (req.reg_addr == `OFS_PRESET_A);
    assign wr_b    = wr_hit && (req.reg_addr == `OFS_PRESET_B);
    assign wr_ctrl = wr_hit && (req.reg_addr == `OFS_RAMP_CTRL);

    // read multiplexer; unmapped offsets read as zero
    assign rd_mux =
        (req.reg_addr == `OFS_PRESET_A)    ? {mode_a_r, code_a_r} :
        (req.reg_addr == `OFS_PRESET_B)    ? {mode_b_r, code_b_r} :
        (req.reg_addr == `OFS_RAMP_CTRL)   ? {4'h0, ramp_down_ps_r, rate_r} :
        (req.reg_addr == `OFS_RAMP_STATUS) ? {(state_r != ST_REG), set_r} :
        8'h00;

    // select low picks preset a, high picks preset b; a register write or a pin
    // change both show up here, so the inactive preset only matters after a switch
    assign target = sel_sync_r ? code_b_r : code_a_r;
    // mode bit clear is power save, set is forced pwm, followed without delay
    assign fpwm   = sel_sync_r ? mode_b_r : mode_a_r;

    // direction of the pending change
    assign rising  = set_r < target;
    assign falling = set_r > target;
    // slope enforced on the way down only in forced pwm or with the ramp-down bit
    assign enforce_down = fpwm || ramp_down_ps_r;
    // rising always follows the slope; falling only when enforced
    assign moving  = rising || (falling && enforce_down);

    // 20 mV increments, a closing 10 mV one when a single code remains
    assign small_step = code_dist(set_r, target) == 7'h01;
    // one rate code for both presets sets the spacing: 32 mV/us over 2^code
    assign need     = step_need(rate_r, small_step);
    // quarter-clock accumulator keeps the average slope exact despite the
    // non-integer clock count per increment; this is the ramp timebase
    assign acc_inc  = ACC_W'(acc_r + ACC_W'(`ACC_FRAC));
    assign step_due = acc_inc >= need;

    // the last counted clock ends soft start, so it lasts exactly SS_CYCLES clocks
    assign ss_done  = ss_cnt_r >= (SS_CYCLES - 1);

    // pin synchronisers
    // both pins are asynchronous to clk; two flops bound the metastability risk
    // at the cost of two clocks before an enable or select change is seen
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            en_meta_r  <= 1'b0;
            en_sync_r  <= 1'b0;
            sel_meta_r <= 1'b0;
            sel_sync_r <= 1'b0;
        end
        else
        begin
            en_meta_r  <= enable_pin;
            en_sync_r  <= en_meta_r;
            sel_meta_r <= preset_select_pin;  // host keeps the pin defined
            sel_sync_r <= sel_meta_r;
        end
    end

    // preset registers; undervoltage reset restores every default
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            // both presets come up in power save with the variant voltages
            code_a_r <= VARIANT ? `RST_A_VAR1 : `RST_A_VAR0;
            code_b_r <= VARIANT ? `RST_B_VAR1 : `RST_B_VAR0;
            mode_a_r <= `RST_MODE;
            mode_b_r <= `RST_MODE;
        end
        else
        begin
            // a write to the inactive preset is only stored; it reaches the loop
            // once the select pin moves over to that preset
            if (wr_a)  // code in bits 6..0, mode in bit 7
            begin
                code_a_r <= req.wdata[`CODE_MSB:0];
                mode_a_r <= req.wdata[`MODE_BIT];
            end
            if (wr_b)
            begin
                code_b_r <= req.wdata[`CODE_MSB:0];
                mode_b_r <= req.wdata[`MODE_BIT];
            end
        end
    end

    // global ramp control register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rate_r         <= `RST_RATE;
            ramp_down_ps_r <= `RST_RAMP_DOWN;
        end
        else if (wr_ctrl)
        begin
            rate_r         <= req.wdata[`RATE_MSB:0];
            ramp_down_ps_r <= req.wdata[`RAMP_DOWN_BIT];
        end
    end

    // sequencer next state: off, soft start, ramp, regulate
    always_comb
    begin
        state_nxt  = state_r;
        set_nxt    = set_r;
        acc_nxt    = '0;
        ss_cnt_nxt = '0;
        if (!en_sync_r)  // enable low stops the converter at once
        begin
            // back to the minimum code so the next start is a clean soft start
            state_nxt = ST_OFF;
            set_nxt   = 7'h00;
        end
        else
        begin
            case (state_r)
                ST_OFF:
                begin
                    // enable high starts soft start from the minimum code
                    state_nxt = ST_SOFT;
                    set_nxt   = 7'h00;
                end
                ST_SOFT:
                begin
                    // the loop rises monotonically to the minimum level; the
                    // setpoint is never pulled below a pre-biased output
                    ss_cnt_nxt = 32'(ss_cnt_r + 32'd1);
                    if (ss_done)
                    begin
                        state_nxt  = ST_RAMP;
                        ss_cnt_nxt = '0;
                    end
                end
                ST_RAMP, ST_REG:
                begin
                    if (moving)
                    begin
                        // timed increment toward the target
                        state_nxt = ST_RAMP;
                        acc_nxt   = acc_inc;
                        if (step_due)
                        begin
                            acc_nxt = ACC_W'(acc_inc - need);
                            if (rising)
                                set_nxt = small_step ? 7'(set_r + 7'h01)
                                                     : 7'(set_r + 7'h02);
                            else
                                set_nxt = small_step ? 7'(set_r - 7'h01)
                                                     : 7'(set_r - 7'h02);
                        end
                    end
                    else if (falling)
                    begin
                        // power save without ramp-down: drop straight to target and let
                        // the load discharge the output
                        // limitation: the real fall rate is set by the load, not the rate code
                        set_nxt   = target;
                        state_nxt = ST_REG;
                    end
                    else
                    begin
                        // target reached: regular operation
                        state_nxt = ST_REG;
                    end
                end
                default:
                begin
                    state_nxt = ST_OFF;
                    set_nxt   = 7'h00;
                end
            endcase
        end
    end

    // loop controls follow the next state so they change with the setpoint
    // registering them costs nothing in latency and keeps glitches off the loop
    always_comb
    begin
        loop_nxt.run        = state_nxt != ST_OFF;
        loop_nxt.soft_start = state_nxt == ST_SOFT;
        loop_nxt.fpwm       = fpwm;
        // power save never returns energy unless the ramp-down bit asks for it;
        // soft start never sinks, which protects a pre-biased output
        loop_nxt.sink_enable = (state_nxt != ST_OFF) && (state_nxt != ST_SOFT)
                               && enforce_down;
        loop_nxt.setpoint   = set_nxt;
    end

    // read data is latched on the accepted read strobe
    // holding the last value keeps the read bus quiet between reads
    assign rd_nxt = rd_hit ? rd_mux : rd_data;

    // sequencer and output registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r  <= ST_OFF;
            set_r    <= 7'h00;
            acc_r    <= '0;
            ss_cnt_r <= '0;
            loop_r   <= '0;
            rd_data  <= 8'h00;
        end
        else
        begin
            state_r  <= state_nxt;
            set_r    <= set_nxt;
            acc_r    <= acc_nxt;
            ss_cnt_r <= ss_cnt_nxt;
            loop_r   <= loop_nxt;
            rd_data  <= rd_nxt;
        end
    end

    assign loop = loop_r;

endmodule : voltage_preset_ramp_sequencer

/* File: test/host_model.sv */
// host side model: completed serial commands plus the enable and preset select pins
module host_model
(
    input  wire logic                    clk,
    output preset_ramp_pkg::reg_req_type req,
    output logic                         enable_pin,
    output logic                         preset_select_pin,
    input  wire logic                    addr_ack,
    input  wire logic [7:0]              rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import preset_ramp_pkg::*;

    // pins start at a defined level, the model never floats them
    initial
    begin
        req               = '0;
        enable_pin        = 1'b0;
        preset_select_pin = 1'b0;
    end

    // pins change just after a falling edge
    task automatic pins(input logic en, input logic sel);
        @(negedge clk);
        enable_pin        = en;
        preset_select_pin = sel;
    endtask : pins

    // one command: strobe stands one clock, then the stale fields are scrambled
    task automatic xfer(input logic [6:0] dev, input logic tb10, input logic gcall,
                        input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                        output logic ack, output logic [7:0] rd);
        reg_req_type idle;          // released bus value
        @(negedge clk);
        req = '{valid: 1'b1, write: wr, ten_bit: tb10, general_call: gcall,
                dev_addr: dev, reg_addr: addr, wdata: wd};
        @(posedge clk);
        ack = addr_ack;
        @(negedge clk);
        rd         = rd_data;
        idle       = ~req;
        idle.valid = 1'b0;
        req        = idle;
    endtask : xfer
endmodule : host_model

/* File: test/seq_props.sv */
// concurrent checks on the ports of the preset ramp sequencer
module seq_props
#(
    parameter int unsigned SS_CYCLES = 10   // soft start duration in clocks
)
(
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic                          enable_pin,
    input  wire logic                          preset_select_pin,
    input  wire preset_ramp_pkg::reg_req_type  req,
    input  wire logic                          addr_ack,
    input  wire logic [7:0]                    rd_data,
    input  wire preset_ramp_pkg::reg_loop_type loop
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MIN_GAP = 70;  // a step never comes sooner, even at the fastest rate
    int unsigned ss_cnt;          // clocks spent in soft start
    int unsigned gap_cnt;         // clocks since the setpoint last moved

    // helper counters, cleared whenever the measured span restarts
    always_ff @(posedge clk)
    begin
        ss_cnt  <= (srst || !loop.soft_start) ? 0 : ss_cnt + 1;
        gap_cnt <= (srst || !loop.run || loop.soft_start || $changed(loop.setpoint))
                   ? 0 : gap_cnt + 1;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence stopped;
        !loop.run && loop.setpoint == 7'h00;
    endsequence
    sequence starting;
        loop.run && loop.soft_start;
    endsequence
    sequence ramping;
        loop.run && !loop.soft_start && $past(loop.run) && !$past(loop.soft_start);
    endsequence

    ack_decode_a: assert property (addr_ack == (req.valid && !req.ten_bit
        && !req.general_call && req.dev_addr == 7'h60)) else $error("bad address ack");
    rdata_hold_a: assert property (!(addr_ack && !req.write) |=> $stable(rd_data))
        else $error("read data moved without a read");
    reset_clear_a: assert property ($fell(srst) |-> stopped ##0 rd_data == 8'h00)
        else $error("outputs not cleared by reset");
    stop_disable_a: assert property ($fell(enable_pin) |-> ##[2:5] stopped)
        else $error("no stop after enable low");
    start_soft_a: assert property ($rose(enable_pin) |-> ##[2:5] starting)
        else $error("no soft start after enable high");
    soft_floor_a: assert property (loop.soft_start |-> loop.run && loop.setpoint == 7'h00)
        else $error("soft start not at minimum level");
    soft_len_a: assert property ($fell(loop.soft_start) && loop.run |->
        ss_cnt + 2 >= SS_CYCLES && ss_cnt <= SS_CYCLES + 2) else $error("soft start length");
    rise_step_a: assert property (ramping ##0 loop.setpoint > $past(loop.setpoint) |->
        loop.setpoint - $past(loop.setpoint) <= 7'h02 && gap_cnt >= MIN_GAP)
        else $error("rising step too big or too soon");
    fall_step_a: assert property (ramping ##0 loop.sink_enable
        ##0 loop.setpoint < $past(loop.setpoint) |->
        $past(loop.setpoint) - loop.setpoint <= 7'h02 && gap_cnt >= MIN_GAP)
        else $error("falling step too big or too soon");
    sink_gate_a: assert property (loop.sink_enable |-> loop.run && !loop.soft_start)
        else $error("sinking outside regulation");
    fpwm_sink_a: assert property (loop.fpwm && loop.run && !loop.soft_start
        |-> ##[0:1] loop.sink_enable) else $error("forced pwm without sinking");
    sel_keep_run_a: assert property (loop.run && enable_pin && $changed(preset_select_pin)
        |=> loop.run) else $error("converter stopped on a preset change");
endmodule : seq_props

bind voltage_preset_ramp_sequencer seq_props #(.SS_CYCLES(SS_CYCLES)) u_props (
    .clk(clk), .srst(srst), .enable_pin(enable_pin), .preset_select_pin(preset_select_pin),
    .req(req), .addr_ack(addr_ack), .rd_data(rd_data), .loop(loop));

/* File: test/tb_top.sv */
// self-checking bench for the preset ramp sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import preset_ramp_pkg::*;

    logic         clk;                // 250 MHz clock
    logic         srst;               // undervoltage reset
    logic         enable_pin;         // from the host model
    logic         preset_select_pin;  // from the host model
    reg_req_type  req;                // completed commands
    logic         addr_ack;
    logic [7:0]   rd_data;
    reg_loop_type loop;               // toward the regulation loop
    int           miscompares;
    int           num_checks;

    host_model host (.clk(clk), .req(req), .enable_pin(enable_pin),
        .preset_select_pin(preset_select_pin), .addr_ack(addr_ack), .rd_data(rd_data));
    // short soft start keeps the run brief
    voltage_preset_ramp_sequencer #(.VARIANT(1'b0), .SS_CYCLES(10)) DUT (.clk(clk),
        .srst(srst), .enable_pin(enable_pin), .preset_select_pin(preset_select_pin),
        .req(req), .addr_ack(addr_ack), .rd_data(rd_data), .loop(loop));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    // cycle counts are judged against a window, since steps alternate by one clock
    task automatic check_rng(input int n, input int lo, input int hi);
        num_checks++;
        if (n < lo || n > hi)
        begin
            miscompares++;
            $display("ERROR at %0t: got %0h expected %0h to %0h", $time, n, lo, hi);
        end
    endtask : check_rng

    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                       output logic [7:0] d);
        logic ack;
        host.xfer(7'h60, 1'b0, 1'b0, wr, a, wd, ack, d);
        check({7'h00, ack}, 8'h01);
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [7:0] wd);
        logic [7:0] d;
        acc(1'b1, a, wd, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        acc(1'b0, a, 8'h00, d);
        check(d, exp);
    endtask : rd_chk

    // clocks until the setpoint reaches the target, bounded
    task automatic wait_sp(input logic [6:0] t, input int lim, output int n);
        n = 0;
        while (loop.setpoint !== t && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        check({1'b0, loop.setpoint}, {1'b0, t});
    endtask : wait_sp

    task automatic test_defaults;
        logic       ack;
        logic [7:0] d;
        rd_chk(8'h00, 8'h46);
        rd_chk(8'h01, 8'h42);
        rd_chk(8'h05, 8'h00);
        // wrong address, ten-bit and general call writes must all be ignored
        for (int i = 0; i < 3; i++)
        begin
            host.xfer((i == 0) ? 7'h61 : 7'h60, i == 1, i == 2, 1'b1, 8'h00, 8'h3C, ack, d);
            check({7'h00, ack}, 8'h00);
        end
        rd_chk(8'h00, 8'h46);
        $display("test_defaults done");
    endtask : test_defaults

    task automatic test_startup;
        int n;
        host.pins(1'b1, 1'b0);
        wait_sp(7'h46, 8000, n);
        check({7'h00, loop.fpwm}, 8'h00);
        rd_chk(8'h07, 8'h46);
        $display("test_startup done");
    endtask : test_startup

    task automatic test_active;
        int n;
        wr(8'h00, 8'hC8);
        repeat (4) @(negedge clk);
        check({7'h00, loop.fpwm}, 8'h01);
        rd_chk(8'h07, 8'hC6);
        wait_sp(7'h48, 400, n);
        check_rng(n, 148, 166);
        wr(8'h00, 8'hC7);
        wait_sp(7'h47, 200, n);
        check_rng(n, 70, 86);
        $display("test_active done");
    endtask : test_active

    task automatic test_inactive;
        int n;
        wr(8'h01, 8'h50);
        repeat (200) @(negedge clk);
        check({1'b0, loop.setpoint}, 8'h47);
        host.pins(1'b1, 1'b1);
        wait_sp(7'h50, 1000, n);
        check_rng(n, 690, 725);
        check({7'h00, loop.fpwm}, 8'h00);
        $display("test_inactive done");
    endtask : test_inactive

    task automatic test_ps_fall;
        int n;
        wr(8'h01, 8'h30);
        wait_sp(7'h30, 20, n);
        check_rng(n, 0, 4);
        wr(8'h06, 8'h08);
        wr(8'h01, 8'h2C);
        wait_sp(7'h2C, 600, n);
        check_rng(n, 300, 325);
        check({7'h00, loop.sink_enable}, 8'h01);
        $display("test_ps_fall done");
    endtask : test_ps_fall

    task automatic test_rate;
        int n;
        wr(8'h06, 8'h09);
        wr(8'h01, 8'h30);
        wait_sp(7'h30, 900, n);
        check_rng(n, 612, 640);
        host.pins(1'b1, 1'b0);
        wait_sp(7'h47, 5000, n);
        check_rng(n, 3575, 3620);
        $display("test_rate done");
    endtask : test_rate

    task automatic test_uv;
        host.pins(1'b0, 1'b0);
        repeat (6) @(negedge clk);
        check({7'h00, loop.run}, 8'h00);
        rd_chk(8'h00, 8'hC7);
        host.pins(1'b1, 1'b0);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        check({1'b0, loop.setpoint}, 8'h00);
        rd_chk(8'h00, 8'h46);
        rd_chk(8'h06, 8'h00);
        $display("test_uv done");
    endtask : test_uv

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    initial
    begin
        srst        = 1'b1;
        miscompares = 0;
        num_checks  = 0;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        test_defaults();
        test_startup();
        test_active();
        test_inactive();
        test_ps_fall();
        test_rate();
        test_uv();
        complete_run();
    end

    // the whole run needs about 11000 clocks
    initial
    begin
        repeat (30000) @(posedge clk);
        miscompares++;
        $display("ERROR at %0t: got %0h expected %0h", $time, 0, 1);
        complete_run();
    end
endmodule : tb_top
